//--- common/eei_regs.vh
// register map, field layout, reset values and timing counts of the edge unit
//
// Behaviour
// - nine inputs: eight maskable, one non-maskable
// - maskable 0-3 on port six, 4-7 port nine
// - low edge register: two-bit fields, inputs 0-3
// - high edge register: two-bit fields, inputs 4-7
// - edge registers read/write, zero on reset events
// - nm edge bits 4-5, priority bit 7, pin bit 6
// - bits 0-3,6 ignore writes; read 0,0,1,1
// - control resets to 0x0C or 0x4C by pin
// - nonexistent register bits read back as one
// - selected edge sets input request flag
// - per-input enable flag gates servicing
// - two priority flags give three levels
// - fixed vector address per maskable input
// - non-maskable blocked until first instruction done
// - nm accept clears flag, blocks maskables, 14 cycles
`ifndef EEI_REGS_VH
`define EEI_REGS_VH

// register indices; byte address is four times the index
`define EEI_IDX_EDGE_LO 8'h58
`define EEI_IDX_EDGE_HI 8'h59
`define EEI_IDX_NM_CTRL 8'h5A
`define EEI_IDX_REQUEST 8'h60
`define EEI_IDX_ENABLE 8'h61
`define EEI_IDX_PRIO_HI 8'h62
`define EEI_IDX_PRIO_LO 8'h63
`define EEI_IDX_STATUS 8'h64
`define EEI_IDX_MASK 8'h65
`define EEI_IDX_CORE 8'h66

// reset values
`define EEI_RST_EDGE 8'h00
`define EEI_RST_NM_CTRL 8'h0C
`define EEI_NM_CTRL_FIXED 8'h0C

// control register fields
`define EEI_NM_SEL_LO 4
`define EEI_NM_SEL_HI 5
`define EEI_NM_PIN_LVL 6
`define EEI_PRIO_EN 7

// edge field codes
`define EEI_EDGE_OFF 2'h0
`define EEI_EDGE_FALL 2'h1
`define EEI_EDGE_RISE 2'h2
`define EEI_EDGE_BOTH 2'h3

// non-maskable transfer time: 14 core cycles
`define EEI_NM_XFER_CYC 4'hE

`endif

//--- rtl/eei_edge_unit.v
// external interrupt edge unit: pin edges, request flags, priority vectoring
`timescale 1ns/100ps
`default_nettype none
`include "eei_regs.vh"

module eei_edge_unit (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // pins: port six bits 0-3, port nine bits 0-3, non-maskable pin
    input wire [3:0] port_six_pin,
    input wire [3:0] port_nine_pin,
    input wire nm_pin,
    // core side
    input wire reset_event,
    input wire first_instr_done,
    input wire maskable_ack,
    input wire nm_accept,
    // vector and request outputs
    output reg vec_valid,
    output reg [15:0] vec_addr,
    output reg [2:0] vec_index,
    output reg nm_request,
    output reg nm_xfer_busy,
    output reg irq
);

    // fixed vector table
    function [15:0] vec_of;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: vec_of = 16'h000A;
                3'h1: vec_of = 16'h001C;
                3'h2: vec_of = 16'h001E;
                3'h3: vec_of = 16'h0020;
                3'h4: vec_of = 16'h002A;
                3'h5: vec_of = 16'h002C;
                3'h6: vec_of = 16'h002E;
                default: vec_of = 16'h0030;
            endcase
        end
    endfunction

    // edge match for one two-bit field
    function edge_hit;
        input [1:0] mode;
        input cur;
        input prev;
        begin
            case (mode)
                `EEI_EDGE_FALL: edge_hit = prev & ~cur;
                `EEI_EDGE_RISE: edge_hit = ~prev & cur;
                `EEI_EDGE_BOTH: edge_hit = prev ^ cur;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    // three priority levels from the flag pair
    function [1:0] level_of;
        input hi;
        input lo;
        begin
            level_of = hi ? 2'h2 : (lo ? 2'h1 : 2'h0);
        end
    endfunction

    // write-one-to-clear hit: a write to one index with a one in the bit
    function clr_hit;
        input en;
        input [7:0] cur;
        input [7:0] at;
        input one;
        begin
            clr_hit = en & (cur == at) & one;
        end
    endfunction

    // software-visible configuration
    reg [7:0] edge_lo_q;
    reg [7:0] edge_hi_q;
    reg [1:0] nm_sel_q;
    reg prio_en_q;
    // event flags and their masks
    reg [7:0] request_q;
    reg [7:0] enable_q;
    reg [7:0] prio_hi_q;
    reg [7:0] prio_lo_q;
    reg [8:0] status_q;
    reg [8:0] mask_q;
    // pin history and core-side state
    reg [8:0] sync1_q;
    reg [8:0] sync2_q;
    reg [8:0] prev_q;
    reg nm_flag_q;
    reg nm_armed_q;
    reg mask_block_q;
    reg [3:0] xfer_cnt_q;
    // combinational helpers, assigned in full by their processes
    reg [15:0] edge_all;
    reg [7:0] hit;
    reg nm_hit;
    reg [7:0] rd_byte;
    reg rd_ok;
    reg [7:0] pend;
    reg found;
    reg [2:0] best_idx;
    reg [1:0] best_lvl;
    reg [1:0] lvl;
    // one loop index per process, so no variable has two drivers
    integer i;
    integer j;
    integer k;

    wire [7:0] idx = paddr[9:2];
    wire wr_en = psel & penable & pready & pwrite;
    wire [7:0] wb = pwdata[7:0];

    // fields of both edge registers side by side, pin order 0..7
    always @* begin
        edge_all = {edge_hi_q, edge_lo_q};
    end

    // edge detection on the synchronised pins
    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            hit[i] = edge_hit(edge_all[2*i +: 2], sync2_q[i], prev_q[i]);
        end
        nm_hit = edge_hit(nm_sel_q, sync2_q[8], prev_q[8]);
    end

    // two-flop synchroniser, then one stage of history for edges
    // only the second stage feeds logic; the first may still be settling
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
            prev_q <= 9'h000;
        end else begin
            sync1_q <= {nm_pin, port_nine_pin, port_six_pin};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // read mux; absent bits read one, control low nibble fixed
    // bit 6 of the control register shows the pin two cycles late
    always @* begin
        rd_ok = 1'b1;
        case (idx)
            `EEI_IDX_EDGE_LO: rd_byte = edge_lo_q;
            `EEI_IDX_EDGE_HI: rd_byte = edge_hi_q;
            `EEI_IDX_NM_CTRL: rd_byte = {prio_en_q, sync2_q[8], nm_sel_q,
                                         4'hC};
            `EEI_IDX_REQUEST: rd_byte = request_q;
            `EEI_IDX_ENABLE: rd_byte = enable_q;
            `EEI_IDX_PRIO_HI: rd_byte = prio_hi_q;
            `EEI_IDX_PRIO_LO: rd_byte = prio_lo_q;
            `EEI_IDX_STATUS: rd_byte = status_q[7:0];
            `EEI_IDX_MASK: rd_byte = mask_q[7:0];
            `EEI_IDX_CORE: rd_byte = {3'h7, status_q[8], mask_q[8], nm_armed_q,
                                      mask_block_q, nm_flag_q};
            default: begin
                rd_byte = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    // apb: ready rises in the access cycle, so every transfer has no wait
    // read data is caught in the setup cycle and stays put through the access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_ok;
            if (psel & ~penable & ~pwrite) begin
                prdata <= {24'h000000, rd_byte};
            end
        end
    end

    // configuration registers; reset event acts as reset here
    // the synchronisers are left alone, so a pin held high gives no false edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_lo_q <= `EEI_RST_EDGE;
            edge_hi_q <= `EEI_RST_EDGE;
            nm_sel_q <= 2'h0;
            prio_en_q <= 1'b0;
            enable_q <= 8'h00;
            prio_hi_q <= 8'h00;
            prio_lo_q <= 8'h00;
            mask_q <= 9'h000;
        end else if (reset_event) begin
            edge_lo_q <= `EEI_RST_EDGE;
            edge_hi_q <= `EEI_RST_EDGE;
            nm_sel_q <= 2'h0;
            prio_en_q <= 1'b0;
            enable_q <= 8'h00;
            prio_hi_q <= 8'h00;
            prio_lo_q <= 8'h00;
            mask_q <= 9'h000;
        end else if (wr_en) begin
            case (idx)
                `EEI_IDX_EDGE_LO: edge_lo_q <= wb;
                `EEI_IDX_EDGE_HI: edge_hi_q <= wb;
                `EEI_IDX_NM_CTRL: begin
                    // only bits 4, 5 and 7 hold state
                    nm_sel_q <= wb[`EEI_NM_SEL_HI:`EEI_NM_SEL_LO];
                    prio_en_q <= wb[`EEI_PRIO_EN];
                end
                `EEI_IDX_ENABLE: enable_q <= wb;
                `EEI_IDX_PRIO_HI: prio_hi_q <= wb;
                `EEI_IDX_PRIO_LO: prio_lo_q <= wb;
                `EEI_IDX_MASK: mask_q[7:0] <= wb;
                `EEI_IDX_CORE: mask_q[8] <= wb[3];
                default: ;
            endcase
        end
    end

    // request flags: an edge in the clearing cycle still sets the flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_q <= 8'h00;
            status_q <= 9'h000;
        end else if (reset_event) begin
            request_q <= 8'h00;
            status_q <= 9'h000;
        end else begin
            // an acknowledge clears only the input whose vector is on show
            for (j = 0; j < 8; j = j + 1) begin
                if (hit[j]) begin
                    request_q[j] <= 1'b1;
                end else if (clr_hit(wr_en, idx, `EEI_IDX_REQUEST, wb[j])) begin
                    request_q[j] <= 1'b0;
                end else if (maskable_ack && vec_valid && vec_index == j[2:0]) begin
                    request_q[j] <= 1'b0;
                end
                if (hit[j]) begin
                    status_q[j] <= 1'b1;
                end else if (clr_hit(wr_en, idx, `EEI_IDX_STATUS, wb[j])) begin
                    status_q[j] <= 1'b0;
                end
            end
            if (nm_hit) begin
                status_q[8] <= 1'b1;
            end else if (clr_hit(wr_en, idx, `EEI_IDX_CORE, wb[4])) begin
                status_q[8] <= 1'b0;
            end
        end
    end

    // non-maskable flag, post-reset block and the transfer window
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nm_flag_q <= 1'b0;
            nm_armed_q <= 1'b0;
            mask_block_q <= 1'b0;
            xfer_cnt_q <= 4'h0;
        end else if (reset_event) begin
            nm_flag_q <= 1'b0;
            nm_armed_q <= 1'b0;
            mask_block_q <= 1'b0;
            xfer_cnt_q <= 4'h0;
        end else begin
            if (first_instr_done) begin
                nm_armed_q <= 1'b1;
            end
            if (nm_hit) begin
                nm_flag_q <= 1'b1;
            end else if (nm_accept && nm_request) begin
                nm_flag_q <= 1'b0;
            end
            // maskables stay blocked until software clears the bit or a reset event arrives
            if (nm_accept && nm_request) begin
                mask_block_q <= 1'b1;
            end else if (clr_hit(wr_en, idx, `EEI_IDX_CORE, wb[1])) begin
                mask_block_q <= 1'b0;
            end
            // a second accept reloads the count and so restarts the window
            if (nm_accept && nm_request) begin
                xfer_cnt_q <= `EEI_NM_XFER_CYC;
            end else if (xfer_cnt_q != 4'h0) begin
                xfer_cnt_q <= xfer_cnt_q - 4'h1;
            end
        end
    end

    // pick the pending, enabled input of highest level, lowest index on a tie
    always @* begin
        pend = request_q & enable_q;
        found = 1'b0;
        best_idx = 3'h0;
        best_lvl = 2'h0;
        lvl = 2'h0;
        for (k = 0; k < 8; k = k + 1) begin
            lvl = prio_en_q ? level_of(prio_hi_q[k], prio_lo_q[k]) : 2'h0;
            if (pend[k] && (!found || lvl > best_lvl)) begin
                found = 1'b1;
                best_idx = k[2:0];
                best_lvl = lvl;
            end
        end
    end

    // registered outputs toward the core
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_valid <= 1'b0;
            vec_addr <= 16'h0000;
            vec_index <= 3'h0;
            nm_request <= 1'b0;
            nm_xfer_busy <= 1'b0;
            irq <= 1'b0;
        end else begin
            // dropped for one cycle after an ack so an ack cannot hit a stale index
            vec_valid <= found & ~mask_block_q & ~(maskable_ack & vec_valid);
            vec_addr <= vec_of(best_idx);
            vec_index <= best_idx;
            nm_request <= nm_flag_q & nm_armed_q & ~(nm_accept & nm_request);
            nm_xfer_busy <= (nm_accept & nm_request) | (xfer_cnt_q > 4'h1);
            // irq follows status and mask only; the enable flags gate vectoring
            irq <= |(status_q & mask_q);
        end
    end

endmodule
`default_nettype wire

//--- test/eei_assertions.sv
// assertion checker for the external interrupt edge unit ports
`timescale 1ns/100ps
`default_nettype none
module eei_checker (
    // clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // core side
    input wire logic reset_event,
    input wire logic first_instr_done,
    input wire logic maskable_ack,
    input wire logic nm_accept,
    input wire logic vec_valid,
    input wire logic [15:0] vec_addr,
    input wire logic [2:0] vec_index,
    input wire logic nm_request,
    input wire logic nm_xfer_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    localparam logic [15:0] vec_map [8] = '{16'h000A, 16'h001C, 16'h001E, 16'h0020,
        16'h002A, 16'h002C, 16'h002E, 16'h0030};
    logic [4:0] busy_q;
    logic armed_q;
    // busy run length and arming; arming is lost on every reset event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 5'h00;
            armed_q <= 1'b0;
        end else begin
            busy_q <= nm_xfer_busy ? busy_q + 5'h01 : 5'h00;
            armed_q <= reset_event ? 1'b0 : (armed_q | first_instr_done);
        end
    end
    a_ready_no_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_vector_table: assert property (vec_valid |-> vec_addr == vec_map[vec_index])
        else $error("vector address does not match index");
    a_ack_drops_vec: assert property (maskable_ack && vec_valid |=> !vec_valid)
        else $error("vector still valid after ack");
    a_nm_accept_clears: assert property (nm_accept && nm_request |=>
        !nm_request && nm_xfer_busy)
        else $error("accept did not clear request");
    a_nm_xfer_len: assert property ($fell(nm_xfer_busy) || busy_q == 5'h0E
        |-> !nm_xfer_busy && busy_q == 5'h0E)
        else $error("transfer busy length wrong");
    a_nm_blocked_early: assert property (!armed_q && !$past(armed_q) |-> !nm_request)
        else $error("nm request before first instruction");
    a_event_clears_vec: assert property (reset_event |-> ##2 !vec_valid)
        else $error("vector valid after reset event");
    c_unmapped: cover property (pslverr);
    c_nm_taken: cover property (nm_accept && nm_request);
    c_vec_taken: cover property (maskable_ack && vec_valid);
endmodule
bind eei_edge_unit eei_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .reset_event(reset_event),
    .first_instr_done(first_instr_done), .maskable_ack(maskable_ack), .nm_accept(nm_accept),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_index(vec_index),
    .nm_request(nm_request), .nm_xfer_busy(nm_xfer_busy));
`default_nettype wire

//--- test/eei_edge_unit_tb_top.sv
// self-checking bench for the external interrupt edge unit
`timescale 1ns/100ps
`default_nettype none
`include "eei_regs.vh"
module eei_edge_unit_tb_top;
    logic pclk, pready, pslverr, vec_valid, nm_request, nm_xfer_busy, irq, nm_pin, er;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] six, nine, core_in = 4'h0;
    logic [15:0] vec_addr;
    logic [2:0] vec_index;
    int err_count = 0;
    int tests_run = 0;
    // rows: index, write value, read-back value, error flag
    logic [24:0] rows [6] = '{{8'h58, 8'hA5, 8'hA5, 1'b0}, {8'h59, 8'h5A, 8'h5A, 1'b0},
        {8'h5A, 8'hFF, 8'hBC, 1'b0}, {8'h5A, 8'h00, 8'h0C, 1'b0},
        {8'h7F, 8'h55, 8'h00, 1'b1}, {8'h61, 8'hFF, 8'hFF, 1'b0}};
    logic [15:0] vec_exp [4] = '{16'h0030, 16'h001C, 16'h0020, 16'h002C};
    eei_edge_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_six_pin(six), .port_nine_pin(nine), .nm_pin(nm_pin),
        .reset_event(core_in[0]), .first_instr_done(core_in[2]),
        .maskable_ack(core_in[1]), .nm_accept(core_in[3]), .vec_valid(vec_valid),
        .vec_addr(vec_addr), .vec_index(vec_index), .nm_request(nm_request),
        .nm_xfer_busy(nm_xfer_busy), .irq(irq));
    eei_pin_model u_pins (.pclk(pclk), .six(six), .nine(nine), .nm(nm_pin));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the request holds until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task automatic pulse(input int b);
        @(posedge pclk);
        core_in[b] <= 1'b1;
        @(posedge pclk);
        core_in[b] <= 1'b0;
    endtask
    task automatic results;
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // the whole run is a few hundred cycles, so this only cuts a hang
    initial begin
        repeat (4000) @(posedge pclk);
        err_count++;
        results();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`EEI_IDX_EDGE_LO, 8'h00);
        rchk(`EEI_IDX_NM_CTRL, 8'h0C);
        foreach (rows[i]) begin
            apb(1'b1, rows[i][24:17], rows[i][16:9]);
            apb(1'b0, rows[i][24:17], 8'h00);
            chk(rd, {24'h0, rows[i][8:1]});
            chk({31'h0, er}, {31'h0, rows[i][0]});
        end
        // inputs 0..7 use codes off, fall, rise, both in turn
        apb(1'b1, `EEI_IDX_EDGE_LO, 8'hE4);
        apb(1'b1, `EEI_IDX_EDGE_HI, 8'hE4);
        apb(1'b1, `EEI_IDX_MASK, 8'hFF);
        u_pins.drive(4'hF, 4'hF, 1'b0);
        repeat (6) @(posedge pclk);
        rchk(`EEI_IDX_REQUEST, 8'hCC);
        apb(1'b1, `EEI_IDX_REQUEST, 8'hFF);
        apb(1'b1, `EEI_IDX_STATUS, 8'hFF);
        u_pins.drive(4'h0, 4'h0, 1'b0);
        repeat (6) @(posedge pclk);
        rchk(`EEI_IDX_REQUEST, 8'hAA);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `EEI_IDX_MASK, 8'h00);
        apb(1'b1, `EEI_IDX_ENABLE, 8'h00);
        repeat (3) @(posedge pclk);
        chk({30'h0, irq, vec_valid}, 32'h0);
        apb(1'b1, `EEI_IDX_ENABLE, 8'hFF);
        apb(1'b1, `EEI_IDX_PRIO_HI, 8'h80);
        apb(1'b1, `EEI_IDX_NM_CTRL, 8'h80);
        // input 7 ranks first, then ties fall to the lowest index
        for (int k = 0; k < 4; k++) begin
            repeat (3) @(posedge pclk);
            chk({15'h0, vec_valid, vec_addr}, {15'h0, 1'b1, vec_exp[k]});
            pulse(1);
        end
        apb(1'b1, `EEI_IDX_NM_CTRL, 8'h20);
        u_pins.drive(4'h0, 4'h0, 1'b1);
        repeat (6) @(posedge pclk);
        chk({31'h0, nm_request}, 32'h0);
        pulse(2);
        repeat (4) @(posedge pclk);
        chk({31'h0, nm_request}, 32'h1);
        pulse(3);
        @(posedge pclk);
        chk({30'h0, nm_request, nm_xfer_busy}, 32'h1);
        repeat (16) @(posedge pclk);
        // maskables stay blocked after the accept until software releases them
        u_pins.drive(4'hF, 4'h0, 1'b1);
        repeat (6) @(posedge pclk);
        chk({31'h0, vec_valid}, 32'h0);
        apb(1'b1, `EEI_IDX_CORE, 8'h02);
        repeat (3) @(posedge pclk);
        chk({15'h0, vec_valid, vec_addr}, {16'h0001, 16'h001E});
        // reset event with a vector on show: enables clear, the vector drops
        pulse(0);
        repeat (4) @(posedge pclk);
        chk({31'h0, vec_valid}, 32'h0);
        rchk(`EEI_IDX_NM_CTRL, 8'h4C);
        rchk(`EEI_IDX_EDGE_HI, 8'h00);
        results();
    end
endmodule
`default_nettype wire

//--- test/eei_pin_model.sv
// far-side drivers of the interrupt pins
`timescale 1ns/100ps
`default_nettype none
module eei_pin_model (
    // clock
    input wire logic pclk,
    // pin levels
    output logic [3:0] six,
    output logic [3:0] nine,
    output logic nm
);
    // all pins idle low so no edge is seen out of reset
    initial begin
        six = 4'h0;
        nine = 4'h0;
        nm = 1'b0;
    end
    // levels change just after an edge, as a board driver would
    task automatic drive(input logic [3:0] s, input logic [3:0] n, input logic m);
        @(posedge pclk);
        six <= s;
        nine <= n;
        nm <= m;
    endtask
endmodule
`default_nettype wire
